/* hw/pwmcg_pkg.sv */
// Package: register map, field layout, timing constants and state types of the gated modulator
// Contract
// - Divider code 0..7 sets tick to 1,2,4,8,32,128,512,2048 clock periods.
// - Polarity bit clear gives normal duty, set gives inverted duty.
// - A period is four sub-cycles of sixty-four ticks each.
// - Six coarse duty bits set active ticks per sub-cycle when fine bits zero.
// - Fine value n adds one tick in the first n sub-cycles.
// - High nibble write loads the full duty, effective from the next period.
// - Modulator runs in HALT and freezes while STOP is asserted.
// - Pin 3 carries main output, pin 2 auxiliary, when their select bits are 11.
// - Main and auxiliary outputs share one period and one duty.
// - Comparator is off after reset and on only while its enable bit is one.
// - Gating bit makes the modulator output depend on the comparator result.
// - Scope bit clear gates main only, set gates main and auxiliary.
// - Routing codes 00, 01 and 11 pick pin and reference inputs for the nodes.
// - Swap set with reference clear forces result to zero, or one if inverted.
// - Internal reference is powered off while the reference-select bit is clear.
// - Debounce on suppresses result pulses under 400 us; off passes them through.
// - Four-bit level code sets threshold to code times supply over sixteen.
// - Comparator runs in HALT and STOP; a result change wakes the chip if enabled.
// - Comparator output pins stay usable as ordinary I/O while enabled.
// - Result reads back as bit three of the comparator control register.
// - Any result change sets the change flag; with both enables the shared request rises.
package pwmcg_pkg;

  localparam logic [5:0] PWMCG_IDX_IRQ_EN   = 6'h0A;
  localparam logic [5:0] PWMCG_IDX_STATUS   = 6'h0B;
  localparam logic [5:0] PWMCG_IDX_CMP_CTRL = 6'h0C;
  localparam logic [5:0] PWMCG_IDX_CMP_CFG  = 6'h0D;
  localparam logic [5:0] PWMCG_IDX_PIN_SEL  = 6'h14;
  localparam logic [5:0] PWMCG_IDX_REF_LVL  = 6'h17;
  localparam logic [5:0] PWMCG_IDX_MOD_CTRL = 6'h20;
  localparam logic [5:0] PWMCG_IDX_DUTY_LO  = 6'h21;
  localparam logic [5:0] PWMCG_IDX_DUTY_HI  = 6'h22;

  localparam int PWMCG_CMP_ON_BIT    = 0;
  localparam int PWMCG_CMP_GATE_BIT  = 1;
  localparam int PWMCG_CMP_SCOPE_BIT = 2;
  localparam int PWMCG_CMP_RES_BIT   = 3;
  localparam int PWMCG_CFG_REF_BIT   = 0;
  localparam int PWMCG_CFG_SWAP_BIT  = 1;
  localparam int PWMCG_CFG_INV_BIT   = 2;
  localparam int PWMCG_CFG_DEB_BIT   = 3;
  localparam int PWMCG_POL_BIT       = 3;
  localparam int PWMCG_FLAG_BIT      = 3;
  localparam int PWMCG_IEC_BIT       = 3;

  localparam logic [3:0]  PWMCG_NIBBLE_RST = 4'h0;
  localparam logic [1:0]  PWMCG_PIN_FN_PWM = 2'h3;
  localparam logic [5:0]  PWMCG_TICK_LAST  = 6'h3F;
  localparam logic [1:0]  PWMCG_SUB_LAST   = 2'h3;

  // Last prescaler count per divider code; a tick fires when the count reaches it
  localparam logic [10:0] PWMCG_DIV_LAST_0 = 11'h000;
  localparam logic [10:0] PWMCG_DIV_LAST_1 = 11'h001;
  localparam logic [10:0] PWMCG_DIV_LAST_2 = 11'h003;
  localparam logic [10:0] PWMCG_DIV_LAST_3 = 11'h007;
  localparam logic [10:0] PWMCG_DIV_LAST_4 = 11'h01F;
  localparam logic [10:0] PWMCG_DIV_LAST_5 = 11'h07F;
  localparam logic [10:0] PWMCG_DIV_LAST_6 = 11'h1FF;
  localparam logic [10:0] PWMCG_DIV_LAST_7 = 11'h7FF;

  localparam int PWMCG_CLK_PERIOD_PS = 4000;
  localparam int PWMCG_DEB_TIME_US   = 400;
  localparam int PWMCG_DEB_CYCLES    = (PWMCG_DEB_TIME_US * 1000000) / PWMCG_CLK_PERIOD_PS;
  localparam int PWMCG_DG_CNT_W      = 17;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [7:0]  address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } pwmcg_avs_req_t;

  typedef struct packed {
    logic        waitrequest;
    logic [31:0] readdata;
  } pwmcg_avs_rsp_t;

  typedef struct packed {
    logic pos_gt_neg;
    logic ref_gt_neg;
    logic ref_gt_pos;
  } pwmcg_cmp_in_t;

  typedef struct packed {
    logic                      out;
    logic [PWMCG_DG_CNT_W-1:0] cnt;
  } pwmcg_dg_state_t;

  typedef struct packed {
    pwmcg_avs_rsp_t rsp;
    logic [2:0]     cmp_ctrl;
    logic [3:0]     cmp_cfg;
    logic [3:0]     pin_sel;
    logic [3:0]     ref_lvl;
    logic [3:0]     mod_ctrl;
    logic [3:0]     duty_lo;
    logic [3:0]     duty_hi;
    logic           duty_pend;
    logic [7:0]     duty_act;
    logic [10:0]    pre_cnt;
    logic [5:0]     tick_cnt;
    logic [1:0]     sub;
    logic           res;
    logic           flag;
    logic           iec;
    logic           pin3;
    logic           pin2;
    logic           pin3_sel;
    logic           pin2_sel;
    logic           ref_en;
    logic           irq;
    logic           wake;
  } pwmcg_state_t;

endpackage

/* hw/pwmcg_deglitch.sv */
// Comparator result filter: a new level passes only after it has been stable LIMIT cycles
`timescale 1ns/1ps
module pwmcg_deglitch
  import pwmcg_pkg::*;
#(
  parameter logic [PWMCG_DG_CNT_W-1:0] LIMIT = PWMCG_DG_CNT_W'(PWMCG_DEB_CYCLES)
) (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic enable,
  input  wire logic din,
  output logic      dout
);

  pwmcg_dg_state_t s_q;
  pwmcg_dg_state_t s_d;

  always_comb begin
    s_d = s_q;
    if (!enable) begin
      s_d.out = din;
      s_d.cnt = '0;
    end else if (din == s_q.out) begin
      s_d.cnt = '0;
    end else if (s_q.cnt >= LIMIT - 1'b1) begin
      s_d.out = din;
      s_d.cnt = '0;
    end else begin
      s_d.cnt = s_q.cnt + 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign dout = s_q.out;

endmodule // pwmcg_deglitch

/* hw/pwmcg_top.sv */
// Gated 6+2 bit modulator with comparator control and Avalon-MM register slave
`timescale 1ns/1ps
module pwmcg_top
  import pwmcg_pkg::*;
#(
  parameter int unsigned DEB_CYCLES = PWMCG_DEB_CYCLES
) (
  input  wire logic            ref_clk,
  input  wire logic            rst_n,
  input  wire pwmcg_avs_req_t  avs_req,
  output pwmcg_avs_rsp_t       avs_rsp,
  input  wire logic            stop_mode,
  input  wire pwmcg_cmp_in_t   cmp_in,
  input  wire logic            shared_pin_irq_enable,
  output logic                 pin3_out,
  output logic                 pin3_pwm_sel,
  output logic                 pin2_out,
  output logic                 pin2_pwm_sel,
  output logic                 comparator_result,
  output logic                 ref_enable,
  output logic [3:0]           ref_level,
  output logic                 shared_pin_irq_request,
  output logic                 wake_req
);

  pwmcg_state_t s_q;
  pwmcg_state_t s_d;

  logic [5:0]  idx;
  logic        acc;
  logic        wr;
  logic [3:0]  wd;
  logic [10:0] div_last;
  logic        tick_en;
  logic        period_end;
  logic [6:0]  width;
  logic        wave;
  logic        inactive;
  logic        gating;
  logic        main_w;
  logic        aux_w;
  logic        cmp_raw;
  logic        dg_out;
  logic [31:0] rd;

  assign idx = avs_req.address[7:2];
  // The request is served on the second cycle, when waitrequest has dropped
  assign acc = (avs_req.read | avs_req.write) & ~s_q.rsp.waitrequest;
  assign wr  = acc & avs_req.write & avs_req.byteenable[0];
  assign wd  = avs_req.writedata[3:0];

  always_comb begin
    case (s_q.mod_ctrl[2:0])
      3'h0:    div_last = PWMCG_DIV_LAST_0;
      3'h1:    div_last = PWMCG_DIV_LAST_1;
      3'h2:    div_last = PWMCG_DIV_LAST_2;
      3'h3:    div_last = PWMCG_DIV_LAST_3;
      3'h4:    div_last = PWMCG_DIV_LAST_4;
      3'h5:    div_last = PWMCG_DIV_LAST_5;
      3'h6:    div_last = PWMCG_DIV_LAST_6;
      default: div_last = PWMCG_DIV_LAST_7;
    endcase
  end

  // Compare with >= so a smaller divider code written mid-count takes effect at once
  assign tick_en    = ~stop_mode & (s_q.pre_cnt >= div_last);
  assign period_end = tick_en & (s_q.tick_cnt == PWMCG_TICK_LAST) & (s_q.sub == PWMCG_SUB_LAST);

  // Fine bits lengthen the first n sub-cycles by one tick
  assign width = {1'b0, s_q.duty_act[7:2]} + {6'h00, (s_q.sub < s_q.duty_act[1:0])};
  assign wave  = ({1'b0, s_q.tick_cnt} < width) ^ s_q.mod_ctrl[PWMCG_POL_BIT];
  assign inactive = s_q.mod_ctrl[PWMCG_POL_BIT];

  assign gating = s_q.cmp_ctrl[PWMCG_CMP_ON_BIT] & s_q.cmp_ctrl[PWMCG_CMP_GATE_BIT];
  assign main_w = (gating & ~s_q.res) ? inactive : wave;
  assign aux_w  = (gating & s_q.cmp_ctrl[PWMCG_CMP_SCOPE_BIT]) ? (s_q.res ? inactive : wave) : wave;

  always_comb begin
    case ({s_q.cmp_cfg[PWMCG_CFG_SWAP_BIT], s_q.cmp_cfg[PWMCG_CFG_REF_BIT]})
      2'h0:    cmp_raw = cmp_in.pos_gt_neg;
      2'h1:    cmp_raw = cmp_in.ref_gt_neg;
      2'h3:    cmp_raw = cmp_in.ref_gt_pos;
      default: cmp_raw = 1'b0;
    endcase
  end

  // Disabled comparator reads zero whatever the invert bit says
  pwmcg_deglitch #(
    .LIMIT (PWMCG_DG_CNT_W'(DEB_CYCLES))
  ) u_deglitch (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .enable  (s_q.cmp_cfg[PWMCG_CFG_DEB_BIT]),
    .din     (s_q.cmp_ctrl[PWMCG_CMP_ON_BIT] & (cmp_raw ^ s_q.cmp_cfg[PWMCG_CFG_INV_BIT])),
    .dout    (dg_out)
  );

  always_comb begin
    rd = '0;
    if (idx == PWMCG_IDX_IRQ_EN) begin
      rd[PWMCG_IEC_BIT] = s_q.iec;
    end else if (idx == PWMCG_IDX_STATUS) begin
      rd[PWMCG_FLAG_BIT] = s_q.flag;
    end else if (idx == PWMCG_IDX_CMP_CTRL) begin
      rd[3:0] = {s_q.res, s_q.cmp_ctrl};
    end else if (idx == PWMCG_IDX_CMP_CFG) begin
      rd[3:0] = s_q.cmp_cfg;
    end else if (idx == PWMCG_IDX_PIN_SEL) begin
      rd[3:0] = s_q.pin_sel;
    end else if (idx == PWMCG_IDX_REF_LVL) begin
      rd[3:0] = s_q.ref_lvl;
    end else if (idx == PWMCG_IDX_MOD_CTRL) begin
      rd[3:0] = s_q.mod_ctrl;
    end else if (idx == PWMCG_IDX_DUTY_LO) begin
      rd[3:0] = s_q.duty_lo;
    end else if (idx == PWMCG_IDX_DUTY_HI) begin
      rd[3:0] = s_q.duty_hi;
    end
  end

  always_comb begin
    s_d = s_q;
    // Bus: one wait cycle, then one cycle with waitrequest low
    if ((avs_req.read | avs_req.write) & s_q.rsp.waitrequest) begin
      s_d.rsp.waitrequest = 1'b0;
      s_d.rsp.readdata    = avs_req.read ? rd : '0;
    end else begin
      s_d.rsp.waitrequest = 1'b1;
    end

    if (wr) begin
      if (idx == PWMCG_IDX_IRQ_EN) begin
        s_d.iec = wd[PWMCG_IEC_BIT];
      end else if (idx == PWMCG_IDX_CMP_CTRL) begin
        s_d.cmp_ctrl = wd[2:0];
      end else if (idx == PWMCG_IDX_CMP_CFG) begin
        s_d.cmp_cfg = wd;
      end else if (idx == PWMCG_IDX_PIN_SEL) begin
        s_d.pin_sel = wd;
      end else if (idx == PWMCG_IDX_REF_LVL) begin
        s_d.ref_lvl = wd;
      end else if (idx == PWMCG_IDX_MOD_CTRL) begin
        s_d.mod_ctrl = wd;
      end else if (idx == PWMCG_IDX_DUTY_LO) begin
        s_d.duty_lo = wd;
      end else if (idx == PWMCG_IDX_DUTY_HI) begin
        s_d.duty_hi   = wd;
        s_d.duty_pend = 1'b1;
      end
    end

    // Staged duty lands only on a period boundary so no period is torn
    if (period_end & s_q.duty_pend & ~(wr & (idx == PWMCG_IDX_DUTY_HI))) begin
      s_d.duty_act  = {s_q.duty_hi, s_q.duty_lo};
      s_d.duty_pend = 1'b0;
    end

    if (tick_en) begin
      s_d.pre_cnt  = '0;
      s_d.tick_cnt = s_q.tick_cnt + 1'b1;
      if (s_q.tick_cnt == PWMCG_TICK_LAST) begin
        s_d.sub = s_q.sub + 1'b1;
      end
    end else if (~stop_mode) begin
      s_d.pre_cnt = s_q.pre_cnt + 1'b1;
    end

    // Result keeps tracking during STOP; it has no stop input
    s_d.res = dg_out;
    // Set wins over a write-one clear in the same cycle
    if (wr & (idx == PWMCG_IDX_STATUS) & wd[PWMCG_FLAG_BIT]) begin
      s_d.flag = 1'b0;
    end
    if (dg_out != s_q.res) begin
      s_d.flag = 1'b1;
    end

    s_d.pin3_sel = (s_q.pin_sel[3:2] == PWMCG_PIN_FN_PWM);
    s_d.pin2_sel = (s_q.pin_sel[1:0] == PWMCG_PIN_FN_PWM);
    s_d.pin3     = s_d.pin3_sel & main_w;
    s_d.pin2     = s_d.pin2_sel & aux_w;
    s_d.ref_en   = s_q.cmp_ctrl[PWMCG_CMP_ON_BIT] & s_q.cmp_cfg[PWMCG_CFG_REF_BIT];
    s_d.wake     = s_q.flag & s_q.iec;
    s_d.irq      = s_q.flag & s_q.iec & shared_pin_irq_enable;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s_q                 <= '0;
      s_q.rsp.waitrequest <= 1'b1;
      s_q.cmp_ctrl        <= 3'h0;
      s_q.mod_ctrl        <= PWMCG_NIBBLE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign avs_rsp                = s_q.rsp;
  assign pin3_out               = s_q.pin3;
  assign pin3_pwm_sel           = s_q.pin3_sel;
  assign pin2_out               = s_q.pin2;
  assign pin2_pwm_sel           = s_q.pin2_sel;
  // Filtered result for the port logic; the pins themselves stay under port control
  assign comparator_result      = s_q.res;
  assign ref_enable             = s_q.ref_en;
  assign ref_level              = s_q.ref_lvl;
  assign shared_pin_irq_request = s_q.irq;
  assign wake_req               = s_q.wake;

  AST_TICK_FULL_RATE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (s_q.mod_ctrl[2:0] == 3'h0) && !stop_mode |-> tick_en)
    else $error("tick missing at divide-by-one");

  AST_TICK_DIV8: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ((s_q.mod_ctrl[2:0] == 3'h3) && tick_en) ##1 ((s_q.mod_ctrl[2:0] == 3'h3) && !stop_mode) [*7] |-> !tick_en)
    else $error("divide-by-eight tick too early");

  AST_SUB_WRAP: assert property (@(posedge ref_clk) disable iff (!rst_n)
    tick_en && (s_q.tick_cnt == PWMCG_TICK_LAST) |=> (s_q.tick_cnt == 6'h00) && (s_q.sub == $past(s_q.sub) + 2'h1))
    else $error("sub-cycle did not advance after 64 ticks");

  AST_FINE_WIDTH: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (s_q.duty_act[1:0] == 2'h0) |-> (width == {1'b0, s_q.duty_act[7:2]}))
    else $error("width differs from coarse duty");

  AST_FINE_EXTRA: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (s_q.sub < s_q.duty_act[1:0]) |-> (width == {1'b0, s_q.duty_act[7:2]} + 7'h01))
    else $error("fine tick missing in early sub-cycle");

  AST_DUTY_AT_PERIOD: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (s_q.duty_act != $past(s_q.duty_act)) |-> $past(period_end) && $past(s_q.duty_pend))
    else $error("duty changed away from a period boundary");

  AST_STOP_FREEZE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    stop_mode |=> $stable(s_q.tick_cnt) && $stable(s_q.pre_cnt))
    else $error("modulator moved during stop");

  AST_PIN3_OFF: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (s_q.pin_sel[3:2] != PWMCG_PIN_FN_PWM) |=> !pin3_out && !pin3_pwm_sel)
    else $error("pin 3 driven while not selected");

  AST_PIN3_WAVE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !gating && (s_q.pin_sel[3:2] == PWMCG_PIN_FN_PWM) |=> pin3_out == $past(wave))
    else $error("pin 3 does not follow the waveform");

  AST_GATE_MAIN: assert property (@(posedge ref_clk) disable iff (!rst_n)
    gating && !s_q.res && pin3_pwm_sel |=> pin3_out == $past(inactive))
    else $error("main output not held inactive under low result");

  AST_CMP_OFF: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!s_q.cmp_ctrl[PWMCG_CMP_ON_BIT] && !s_q.cmp_cfg[PWMCG_CFG_DEB_BIT]) [*3] |-> !comparator_result)
    else $error("result high while comparator off");

  AST_FORCED: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_q.cmp_cfg[PWMCG_CFG_SWAP_BIT] && !s_q.cmp_cfg[PWMCG_CFG_REF_BIT] |-> !cmp_raw)
    else $error("swap without reference did not force result");

  AST_REF_OFF: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !s_q.cmp_cfg[PWMCG_CFG_REF_BIT] |=> !ref_enable)
    else $error("reference powered while not selected");

  AST_RESULT_READ: assert property (@(posedge ref_clk) disable iff (!rst_n)
    avs_req.read && s_q.rsp.waitrequest && (idx == PWMCG_IDX_CMP_CTRL)
      |=> avs_rsp.readdata[PWMCG_CMP_RES_BIT] == $past(s_q.res))
    else $error("result bit not returned on read");

  AST_CHANGE_FLAG: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (s_q.res != $past(s_q.res)) |-> s_q.flag ##2 (!s_q.iec || !shared_pin_irq_enable || shared_pin_irq_request))
    else $error("result change did not set flag");

  COV_PERIOD: cover property (@(posedge ref_clk) disable iff (!rst_n) period_end);
  COV_GATED_AUX: cover property (@(posedge ref_clk) disable iff (!rst_n)
    gating && s_q.cmp_ctrl[PWMCG_CMP_SCOPE_BIT] && pin2_out);
  COV_DUTY_LOAD: cover property (@(posedge ref_clk) disable iff (!rst_n) period_end && s_q.duty_pend);
  COV_IRQ: cover property (@(posedge ref_clk) disable iff (!rst_n) shared_pin_irq_request);

endmodule // pwmcg_top

/* test/pwmcg_fan_model.sv */
// Far-side model: analog sense front end of the fan stage and the reference ladder
`timescale 1ns/1ps
module pwmcg_fan_model
  import pwmcg_pkg::*;
#(
  parameter int VDD_MV = 5000
) (
  input  wire logic        ref_enable,
  input  wire logic [3:0]  ref_level,
  input  wire logic [15:0] pos_mv,
  input  wire logic [15:0] neg_mv,
  output pwmcg_cmp_in_t    cmp_in
);
  int ref_mv;
  // An unpowered ladder sits at ground, so no reference comparison can trip
  assign ref_mv = ref_enable ? int'(ref_level) * VDD_MV / 16 : 0;
  assign cmp_in.pos_gt_neg = pos_mv > neg_mv;
  assign cmp_in.ref_gt_neg = ref_mv > int'(neg_mv);
  assign cmp_in.ref_gt_pos = ref_mv > int'(pos_mv);
endmodule // pwmcg_fan_model

/* test/pwmcg_top_tb.sv */
// Bench: register access, waveform counts, comparator routing, filter and wake paths
`timescale 1ns/1ps
module pwmcg_top_tb;
  import pwmcg_pkg::*;
  localparam int  VDD_MV = 5000;
  logic           ref_clk = 1'b0;
  logic           rst_n = 1'b0;
  pwmcg_avs_req_t avs_req = '0;
  pwmcg_avs_rsp_t avs_rsp;
  logic           stop_mode = 1'b0;
  logic           shared_pin_irq_enable = 1'b0;
  pwmcg_cmp_in_t  cmp_in;
  logic           pin3_out, pin3_pwm_sel, pin2_out, pin2_pwm_sel;
  logic           comparator_result, ref_enable, shared_pin_irq_request, wake_req;
  logic [3:0]     ref_level;
  logic [15:0]    pos_mv = 16'h03E8;
  logic [15:0]    neg_mv = 16'h07D0;
  logic [31:0]    seed = 32'h0000E8F1;
  logic [31:0]    rq[$];
  logic [31:0]    pq[$];
  // Last entry is an unmapped index
  logic [5:0]     idx_tab[10] = '{6'h0A, 6'h0B, 6'h0C, 6'h0D, 6'h14, 6'h17, 6'h20, 6'h21, 6'h22, 6'h3F};
  int             mismatches = 0;
  int             samples_checked = 0;
  int             meas_len = 0;
  int             prev_d = 1;
  logic           meas_go = 1'b0;

  always #2 ref_clk = ~ref_clk;

  pwmcg_top #(.DEB_CYCLES(8)) u_pwmcg_top (
    .ref_clk(ref_clk), .rst_n(rst_n), .avs_req(avs_req), .avs_rsp(avs_rsp), .stop_mode(stop_mode),
    .cmp_in(cmp_in), .shared_pin_irq_enable(shared_pin_irq_enable), .pin3_out(pin3_out),
    .pin3_pwm_sel(pin3_pwm_sel), .pin2_out(pin2_out), .pin2_pwm_sel(pin2_pwm_sel),
    .comparator_result(comparator_result), .ref_enable(ref_enable), .ref_level(ref_level),
    .shared_pin_irq_request(shared_pin_irq_request), .wake_req(wake_req)
  );

  pwmcg_fan_model #(.VDD_MV(VDD_MV)) u_pwmcg_fan_model (
    .ref_enable(ref_enable), .ref_level(ref_level), .pos_mv(pos_mv), .neg_mv(neg_mv), .cmp_in(cmp_in)
  );

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("Counts: %0d mismatches, %0d checked", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic done(input string s);
    $display("Test %s done at %0t", s, $time);
  endtask

  task automatic bus(input logic wr, input logic [5:0] idx, input logic [3:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_req.read <= ~wr;
    avs_req.write <= wr;
    avs_req.address <= {idx, 2'b00};
    avs_req.writedata <= {28'h0, d};
    avs_req.byteenable <= 4'hF;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_rsp.waitrequest !== 1'b0 && n < 50);
    if (n >= 50) mismatches++;
    avs_req.read <= 1'b0;
    avs_req.write <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] idx, input logic [3:0] d);
    bus(1'b1, idx, d);
  endtask

  task automatic rd(input logic [5:0] idx, input logic [3:0] exp);
    rq.push_back({28'h0, exp});
    bus(1'b0, idx, 4'h0);
  endtask

  // Mode per pin: 0 held low, 1 carries the wave, 2 parked at the inactive level
  task automatic pwm(input logic [2:0] dc, input logic pol, input logic [7:0] du, input int m3, input int m2);
    int d;
    int hi;
    int full;
    d = 1 << (dc < 4 ? dc : 2 * dc - 3);
    hi = d * (4 * du[7:2] + du[1:0]);
    full = pol ? 256 * d : 0;
    if (pol) hi = 256 * d - hi;
    wr(PWMCG_IDX_MOD_CTRL, {pol, dc});
    rd(PWMCG_IDX_MOD_CTRL, {pol, dc});
    wr(PWMCG_IDX_DUTY_LO, du[3:0]);
    wr(PWMCG_IDX_DUTY_HI, du[7:4]);
    // Old period may still run at the old rate; a new duty lands one or two boundaries later
    repeat (256 * (prev_d + 2 * d) + 16) @(posedge ref_clk);
    prev_d = d;
    pq.push_back({16'(m3 == 1 ? hi : m3 == 2 ? full : 0), 16'(m2 == 1 ? hi : m2 == 2 ? full : 0)});
    meas_len = 256 * d;
    meas_go = 1'b1;
    wait (!meas_go);
  endtask

  task automatic set_res(input logic r);
    pos_mv <= r ? 16'h0BB8 : 16'h03E8;
    neg_mv <= 16'h07D0;
    repeat (4) @(posedge ref_clk);
  endtask

  always @(posedge ref_clk) begin
    if (avs_req.read && avs_rsp.waitrequest === 1'b0 && rq.size() > 0) begin
      check(avs_rsp.readdata, rq.pop_front());
    end
  end

  // A whole period holds the same high count at any phase, so no alignment is needed
  initial begin
    int c3;
    int c2;
    forever begin
      wait (meas_go);
      c3 = 0;
      c2 = 0;
      repeat (meas_len) begin
        @(posedge ref_clk);
        c3 += int'(pin3_out === 1'b1);
        c2 += int'(pin2_out === 1'b1);
      end
      check({c3[15:0], c2[15:0]}, pq.pop_front());
      meas_go = 1'b0;
    end
  end

  initial begin
    repeat (100000) @(posedge ref_clk);
    mismatches++;
    finish_test();
  end

  initial begin
    logic [31:0] r;
    logic        v;
    logic        raw;
    int          n;
    int          refv;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    foreach (idx_tab[i]) rd(idx_tab[i], 4'h0);
    wr(6'h3F, 4'hF);
    rd(6'h3F, 4'h0);
    check({comparator_result, ref_enable}, 2'b00);
    r = rnd();
    wr(PWMCG_IDX_PIN_SEL, 4'hF);
    wr(PWMCG_IDX_REF_LVL, r[3:0]);
    rd(PWMCG_IDX_REF_LVL, r[3:0]);
    check({pin3_pwm_sel, pin2_pwm_sel, ref_level}, {2'b11, r[3:0]});
    done("registers");
    for (int i = 0; i < 5; i++) begin
      r = rnd();
      pwm(3'(i), r[8], {r[7:2], 2'(i)}, 1, 1);
    end
    done("waveform");
    wr(PWMCG_IDX_CMP_CFG, 4'h4);
    rd(PWMCG_IDX_CMP_CTRL, 4'h0);
    wr(PWMCG_IDX_CMP_CTRL, 4'h1);
    for (int i = 0; i < 16; i++) begin
      r = rnd();
      pos_mv <= {4'h0, r[11:0]};
      neg_mv <= {4'h0, r[23:12]};
      wr(PWMCG_IDX_REF_LVL, r[27:24]);
      wr(PWMCG_IDX_CMP_CFG, {1'b0, 3'(i)});
      repeat (4) @(posedge ref_clk);
      refv = int'(r[27:24]) * VDD_MV / 16;
      raw = i[1] ? (i[0] && refv > int'(r[11:0])) : (i[0] ? refv > int'(r[23:12]) : r[11:0] > r[23:12]);
      rd(PWMCG_IDX_CMP_CTRL, {raw ^ i[2], 3'b001});
      check(ref_enable, i[0]);
    end
    done("comparator");
    r = rnd();
    wr(PWMCG_IDX_CMP_CFG, 4'h0);
    set_res(1'b1);
    wr(PWMCG_IDX_CMP_CTRL, 4'h7);
    pwm(3'd0, 1'b1, r[7:0], 1, 2);
    set_res(1'b0);
    pwm(3'd0, 1'b1, r[7:0], 2, 1);
    wr(PWMCG_IDX_CMP_CTRL, 4'h3);
    pwm(3'd0, 1'b0, r[15:8], 2, 1);
    wr(PWMCG_IDX_CMP_CTRL, 4'h1);
    pwm(3'd0, 1'b0, r[15:8], 1, 1);
    wr(PWMCG_IDX_PIN_SEL, 4'h0);
    pwm(3'd0, 1'b1, r[15:8], 0, 0);
    done("gating");
    wr(PWMCG_IDX_CMP_CFG, 4'h8);
    pos_mv <= 16'h0BB8;
    repeat (4) @(posedge ref_clk);
    pos_mv <= 16'h03E8;
    repeat (16) @(posedge ref_clk);
    rd(PWMCG_IDX_CMP_CTRL, 4'h1);
    set_res(1'b1);
    repeat (12) @(posedge ref_clk);
    rd(PWMCG_IDX_CMP_CTRL, 4'h9);
    done("debounce");
    wr(PWMCG_IDX_CMP_CFG, 4'h0);
    wr(PWMCG_IDX_PIN_SEL, 4'hF);
    pwm(3'd0, 1'b0, 8'h80, 1, 1);
    wr(PWMCG_IDX_STATUS, 4'h8);
    rd(PWMCG_IDX_STATUS, 4'h0);
    wr(PWMCG_IDX_IRQ_EN, 4'h8);
    shared_pin_irq_enable <= 1'b1;
    stop_mode <= 1'b1;
    repeat (3) @(posedge ref_clk);
    v = pin3_out;
    n = 0;
    repeat (300) begin
      @(posedge ref_clk);
      n += int'(pin3_out !== v);
    end
    check(n, 0);
    check({wake_req, shared_pin_irq_request}, 2'b00);
    set_res(1'b0);
    check({comparator_result, wake_req, shared_pin_irq_request}, 3'b011);
    rd(PWMCG_IDX_STATUS, 4'h8);
    shared_pin_irq_enable <= 1'b0;
    repeat (2) @(posedge ref_clk);
    check({wake_req, shared_pin_irq_request}, 2'b10);
    wr(PWMCG_IDX_STATUS, 4'h8);
    rd(PWMCG_IDX_STATUS, 4'h0);
    check(wake_req, 1'b0);
    stop_mode <= 1'b0;
    done("wake");
    for (int i = 5; i < 8; i++) begin
      wr(PWMCG_IDX_MOD_CTRL, 4'(i));
      rd(PWMCG_IDX_MOD_CTRL, 4'(i));
    end
    done("slow dividers");
    finish_test();
  end
endmodule // pwmcg_top_tb
